// File: spsb_pkg.sv
package spsb_pkg;
   // ------------------------------------------------------------
   // clock and serial rates
   // ------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int BAUD_300 = 300;
   localparam int BAUD_1200 = 1200;
   localparam int BAUD_2400 = 2400;
   localparam int BAUD_9600 = 9600;
   localparam int BIT_CYC_9600 = CLK_HZ / BAUD_9600;
   // ------------------------------------------------------------
   // buffers
   // ------------------------------------------------------------
   localparam int TX_DEPTH_DEF = 32;
   localparam int RX_DEPTH_DEF = 32;
   localparam int BLOCK_LEN = 32;
   // ------------------------------------------------------------
   // command codes and open directions
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_OPEN = 8'h03;
   localparam logic [7:0] CMD_CLOSE = 8'h0C;
   localparam logic [7:0] CMD_STATUS = 8'h0D;
   localparam logic [7:0] CMD_FORCE = 8'h20;
   localparam logic [7:0] CMD_BAUD = 8'h24;
   localparam logic [7:0] CMD_XLAT = 8'h26;
   localparam logic [7:0] CMD_START = 8'h28;
   localparam logic [7:0] DIR_IN_C = 8'h05;
   localparam logic [7:0] DIR_OUT_B = 8'h08;
   localparam logic [7:0] DIR_OUT_C = 8'h09;
   localparam logic [7:0] DIR_IO_C = 8'h0D;
   // ------------------------------------------------------------
   // characters and configuration fields
   // ------------------------------------------------------------
   localparam logic [7:0] CHR_CR = 8'h0D;
   localparam logic [7:0] CHR_EOL = 8'h9B;
   localparam int CFG_BAUD_LSB = 0;
   localparam int CFG_WSZ_LSB = 4;
   localparam int CFG_XLAT_BIT = 0;
   localparam int CFG_PAR_BIT = 2;
   localparam logic [1:0] WSZ_8 = 2'h3;
   localparam logic [1:0] BAUD_RST = 2'h0;
   typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} spsb_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spsb_rx_t;
endpackage : spsb_pkg

// File: spsb_mem_if.sv
`timescale 1ns/100ps
interface spsb_mem_if #(parameter int AW = 5);
   logic we;
   logic [AW-1:0] waddr;
   logic [7:0] wdata;
   logic [AW-1:0] raddr;
   logic [7:0] rdata;
   modport user(output we, waddr, wdata, raddr, input rdata);
   modport mem(input we, waddr, wdata, raddr, output rdata);
endinterface : spsb_mem_if

// File: spsb_ram.sv
`timescale 1ns/100ps
module spsb_ram #(parameter int AW = 5)
(
   input wire logic clock,
   spsb_mem_if.mem bus
);
   logic [7:0] cells [2**AW];

   // read data registered; a same-address write returns the old byte
   always_ff @(posedge clock)
   begin
      if (bus.we)
         cells[bus.waddr] <= bus.wdata;
      bus.rdata <= cells[bus.raddr];
   end
endmodule : spsb_ram

// File: spsb_port.sv
// Function
// - one open channel per port; a second open is refused
// - ports one to four accepted; index zero means port one
// - concurrent mode ends only through close of its channel
// - close of the last opened or started port drops receive data and sends all pending transmit data
// - close leaves port configuration unchanged
// - system reset closes all channels and drops buffers
// - start concurrent is code 40 on open channel, aux zero
// - concurrent receive buffer 32 bytes by default, may be larger
// - reception only in concurrent mode with input permission
// - block output moves in groups of 32 characters
// - short words transmit in block mode only; 8 bits in both
// - concurrent transmit buffer drains whenever it holds data
// - full transmit buffer stalls writer; occupancy is reported
// - full duplex allowed in concurrent; block output then barred
// - short word reception half duplex and at most 300 baud
// - receive overflow overwrites oldest and records data lost
// - status reports receive count, receive and parity errors
// - translation maps terminator to CR out and CR back in
// - open direction codes 5, 8, 9 and 13
// - block buffer also sent on CR, full buffer or close of the last opened port
`timescale 1ns/100ps
module spsb_port
   import spsb_pkg::*;
#(
   parameter int TX_DEPTH = TX_DEPTH_DEF,
   parameter int RX_DEPTH = RX_DEPTH_DEF,
   parameter int BIT_CYC_300 = CLK_HZ / BAUD_300,
   parameter int BIT_CYC_1200 = CLK_HZ / BAUD_1200,
   parameter int BIT_CYC_2400 = CLK_HZ / BAUD_2400
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [2:0] port_device_specifier,
   input wire logic [7:0] first_aux_parameter,
   input wire logic [7:0] second_aux_parameter,
   output logic cmd_done,
   output logic cmd_ok,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   output logic [$clog2(RX_DEPTH+1)-1:0] st_rx_count,
   output logic [$clog2(TX_DEPTH+1)-1:0] st_tx_count,
   output logic st_lost,
   output logic st_rx_err,
   output logic st_parity_err,
   input wire logic [3:0] rxd,
   output logic [3:0] txd
);
   localparam int TAW = $clog2(TX_DEPTH);
   localparam int RAW = $clog2(RX_DEPTH);
   localparam int TCW = $clog2(TX_DEPTH+1);
   localparam int RCW = $clog2(RX_DEPTH+1);
   localparam logic [TCW-1:0] TX_FULL = TCW'(TX_DEPTH);
   // a buffer shallower than a block sends its group when it fills
   localparam logic [TCW-1:0] BLK_LAST =
      TCW'((TX_DEPTH < BLOCK_LEN ? TX_DEPTH : BLOCK_LEN) - 1);
   localparam logic [RCW-1:0] RX_FULL = RCW'(RX_DEPTH);

   typedef struct packed {
      logic [3:0] open, dirin, dirout, blk, xlat, par;
      logic [3:0][1:0] baud, wsz;
      logic [1:0] cport;
      logic conc, closing, blk_send;
      logic cmd_done, cmd_ok, lost, ferr, perr;
      logic st_lost, st_ferr, st_perr;
      logic [RCW-1:0] rxcnt, st_rx;
      logic [TCW-1:0] txcnt, st_tx;
      logic [TAW-1:0] txwp, txrp;
      logic [RAW-1:0] rxwp, rxrp;
      spsb_tx_t txst;
      logic [9:0] txsh;
      logic [3:0] txbits, rxbits;
      logic [15:0] txdiv, rxdiv;
      logic [3:0] txd, sync1, sync2;
      spsb_rx_t rxst;
      logic [8:0] rxsh;
      logic rd_pend, sk0v, sk1v, tx_ready;
      logic [7:0] sk0d, sk1d;
   } spsb_state_t;

   spsb_state_t s, n;
   logic [1:0] p;
   logic pok, acc, tpush, tpop, rpush, rpop, rinc, clr_rx, rxon, rbit;
   logic w8, wok;
   logic [15:0] div;
   logic [3:0] nb, nrx;
   logic [7:0] tdat, rbyte;
   logic [8:0] rword;

   spsb_mem_if #(.AW(TAW)) txq();
   spsb_mem_if #(.AW(RAW)) rxq();
   spsb_ram #(.AW(TAW)) u_txram (.clock(clock), .bus(txq.mem));
   spsb_ram #(.AW(RAW)) u_rxram (.clock(clock), .bus(rxq.mem));

   function automatic logic [15:0] bit_cyc(input logic [1:0] idx);
      unique case (idx)
         2'h0: bit_cyc = 16'(BIT_CYC_300 - 1);
         2'h1: bit_cyc = 16'(BIT_CYC_1200 - 1);
         2'h2: bit_cyc = 16'(BIT_CYC_2400 - 1);
         2'h3: bit_cyc = 16'(BIT_CYC_9600 - 1);
      endcase
   endfunction : bit_cyc

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      n = s;
      n.cmd_done = 1'b0;
      clr_rx = 1'b0;
      p = (port_device_specifier == 3'h0) ? 2'h0 :
         2'(port_device_specifier - 3'h1);
      pok = (port_device_specifier <= 3'h4);
      acc = cmd_valid && !s.closing;
      w8 = (s.wsz[p] == WSZ_8);
      // short words: no output, no duplex, 300 baud only
      wok = (!s.dirout[p] || w8) && (!s.dirin[p] || w8 ||
         (!s.dirout[p] && s.baud[p] == BAUD_RST));
      div = bit_cyc(s.baud[s.cport]);
      nb = 4'({2'h0, s.wsz[s.cport]}) + 4'h5;
      nrx = nb + {3'h0, s.par[s.cport]};
      // ------------------------------------------------------------
      // host commands
      // ------------------------------------------------------------
      if (acc)
      begin
         n.cmd_done = 1'b1;
         n.cmd_ok = 1'b0;
         // the concurrent channel locks out every other port
         if (pok && !(s.conc && p != s.cport))
         begin
            unique case (cmd_code)
               CMD_OPEN:
                  if (!s.open[p] && (first_aux_parameter == DIR_IN_C ||
                     first_aux_parameter == DIR_OUT_B ||
                     first_aux_parameter == DIR_OUT_C ||
                     first_aux_parameter == DIR_IO_C))
                  begin
                     n.open[p] = 1'b1;
                     n.dirin[p] = first_aux_parameter[2];
                     n.dirout[p] = first_aux_parameter[3];
                     n.blk[p] = (first_aux_parameter == DIR_OUT_B);
                     n.cport = p;
                     n.cmd_ok = 1'b1;
                  end
               CMD_CLOSE:
                  if (s.open[p] && p == s.cport)
                  begin
                     n.closing = 1'b1;
                     n.cmd_done = 1'b0;
                     clr_rx = 1'b1;
                  end
                  else if (s.open[p])
                  begin
                     n.open[p] = 1'b0;
                     n.cmd_ok = 1'b1;
                  end
               CMD_START:
                  if (s.open[p] && !s.conc && !s.blk[p] && wok &&
                     first_aux_parameter == 8'h00 &&
                     second_aux_parameter == 8'h00)
                  begin
                     n.conc = 1'b1;
                     n.cport = p;
                     n.cmd_ok = 1'b1;
                  end
               CMD_BAUD:
                  if (!s.conc)
                  begin
                     n.baud[p] = first_aux_parameter[CFG_BAUD_LSB +: 2];
                     n.wsz[p] = first_aux_parameter[CFG_WSZ_LSB +: 2];
                     n.cmd_ok = 1'b1;
                  end
               CMD_XLAT:
                  if (!s.conc)
                  begin
                     n.xlat[p] = first_aux_parameter[CFG_XLAT_BIT];
                     n.par[p] = first_aux_parameter[CFG_PAR_BIT];
                     n.cmd_ok = 1'b1;
                  end
               CMD_FORCE:
                  if (s.open[p] && s.blk[p] && p == s.cport)
                  begin
                     n.blk_send = (s.txcnt != '0);
                     n.cmd_ok = 1'b1;
                  end
               CMD_STATUS:
                  if (s.open[p])
                  begin
                     n.st_rx = s.rxcnt;
                     n.st_tx = s.txcnt;
                     n.st_lost = s.lost;
                     n.st_ferr = s.ferr;
                     n.st_perr = s.perr;
                     n.lost = 1'b0;
                     n.ferr = 1'b0;
                     n.perr = 1'b0;
                     n.cmd_ok = 1'b1;
                  end
               default: ;
            endcase
         end
      end
      // ------------------------------------------------------------
      // transmit buffer and shifter
      // ------------------------------------------------------------
      tdat = (s.xlat[s.cport] && tx_data == CHR_EOL) ? CHR_CR :
         tx_data;
      tpush = tx_valid && s.tx_ready;
      tpop = 1'b0;
      txq.we = tpush;
      txq.waddr = s.txwp;
      txq.wdata = tdat;
      txq.raddr = s.txrp;
      if (tpush)
      begin
         n.txwp = s.txwp + 1'b1;
         if (!s.conc && (tdat == CHR_CR || s.txcnt == BLK_LAST))
            n.blk_send = 1'b1;
      end
      unique case (s.txst)
         TX_IDLE:
         begin
            n.txd = '1;
            if ((s.conc || s.blk_send || s.closing) && s.txcnt != '0)
            begin
               tpop = 1'b1;
               n.txrp = s.txrp + 1'b1;
               n.txst = TX_LOAD;
            end
            else if (s.blk_send)
               n.blk_send = 1'b0;
         end
         TX_LOAD:
         begin
            // unused upper data bits read as stop level
            n.txsh = {1'b1, txq.rdata | 8'(8'hFF << nb), 1'b0};
            n.txbits = nb + 4'h2;
            n.txdiv = div;
            n.txst = TX_SHIFT;
         end
         TX_SHIFT:
         begin
            n.txd[s.cport] = s.txsh[0];
            n.txdiv = s.txdiv - 16'h0001;
            if (s.txdiv == 16'h0000)
            begin
               n.txsh = {1'b1, s.txsh[9:1]};
               n.txbits = s.txbits - 4'h1;
               n.txdiv = div;
               if (s.txbits == 4'h1)
                  n.txst = TX_IDLE;
            end
         end
      endcase
      n.txcnt = TCW'(s.txcnt + TCW'(tpush) - TCW'(tpop));
      // ------------------------------------------------------------
      // receive path, reader side
      // ------------------------------------------------------------
      rpop = (s.rxcnt != '0) && !s.rd_pend && !s.sk1v;
      rxq.raddr = s.rxrp;
      n.rd_pend = rpop;
      if (rpop)
         n.rxrp = s.rxrp + 1'b1;
      if (s.sk0v && rx_ready)
      begin
         n.sk0v = s.sk1v;
         n.sk0d = s.sk1d;
         n.sk1v = 1'b0;
      end
      if (s.rd_pend && !n.sk0v)
      begin
         n.sk0v = 1'b1;
         n.sk0d = rxq.rdata;
      end
      else if (s.rd_pend)
      begin
         n.sk1v = 1'b1;
         n.sk1d = rxq.rdata;
      end
      // ------------------------------------------------------------
      // receive shifter
      // ------------------------------------------------------------
      n.sync1 = rxd;
      n.sync2 = s.sync1;
      rbit = s.sync2[s.cport];
      rxon = s.conc && s.dirin[s.cport] && !s.closing;
      rpush = 1'b0;
      rword = 9'(s.rxsh >> (4'h9 - nrx));
      rbyte = rword[7:0] & ~8'(8'hFF << nb);
      if (s.rxst != RX_IDLE)
         n.rxdiv = (s.rxdiv == 16'h0000) ? div : s.rxdiv - 16'h0001;
      unique case (s.rxst)
         RX_IDLE:
            if (rxon && !rbit)
            begin
               n.rxst = RX_START;
               n.rxdiv = div >> 1;
            end
         RX_START:
            if (s.rxdiv == 16'h0000)
            begin
               n.rxst = rbit ? RX_IDLE : RX_DATA;
               n.rxbits = 4'h0;
            end
         RX_DATA:
            if (s.rxdiv == 16'h0000)
            begin
               n.rxsh = {rbit, s.rxsh[8:1]};
               n.rxbits = s.rxbits + 4'h1;
               if (s.rxbits + 4'h1 == nrx)
                  n.rxst = RX_STOP;
            end
         RX_STOP:
            if (s.rxdiv == 16'h0000)
            begin
               n.rxst = RX_IDLE;
               rpush = 1'b1;
               if (!rbit)
                  n.ferr = 1'b1;
               if (s.par[s.cport] && ^(rword & ~9'(9'h1FF << nrx)))
                  n.perr = 1'b1;
            end
      endcase
      rxq.we = rpush;
      rxq.waddr = s.rxwp;
      rxq.wdata = (s.xlat[s.cport] && rbyte == CHR_CR) ? CHR_EOL :
         rbyte;
      rinc = rpush && (s.rxcnt != RX_FULL || rpop);
      if (rpush)
         n.rxwp = s.rxwp + 1'b1;
      // full buffer: the oldest byte gives way to the new one
      if (rpush && !rinc)
      begin
         n.rxrp = s.rxrp + 1'b1;
         n.lost = 1'b1;
      end
      n.rxcnt = RCW'(s.rxcnt + RCW'(rinc) - RCW'(rpop));
      // ------------------------------------------------------------
      // close: discard input, finish when output has drained
      // ------------------------------------------------------------
      if (clr_rx)
      begin
         n.rxcnt = '0;
         n.rxrp = n.rxwp;
         n.rd_pend = 1'b0;
         n.sk0v = 1'b0;
         n.sk1v = 1'b0;
         n.rxst = RX_IDLE;
      end
      if (s.closing && s.txst == TX_IDLE && s.txcnt == '0)
      begin
         n.open[s.cport] = 1'b0;
         n.conc = 1'b0;
         n.closing = 1'b0;
         n.blk_send = 1'b0;
         n.cmd_done = 1'b1;
         n.cmd_ok = 1'b1;
      end
      // host waits out a block; full duplex bars block output
      n.tx_ready = n.open[n.cport] && n.dirout[n.cport] && !n.closing &&
         (n.conc || (n.blk[n.cport] && !n.blk_send)) &&
         n.txcnt < TX_FULL;
   end

   // reset cuts any character in flight and empties both buffers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.txd <= '1;
         s.sync1 <= '1;
         s.sync2 <= '1;
         s.wsz <= {4{WSZ_8}};
      end
      else
         s <= n;
   end

   assign cmd_done = s.cmd_done;
   assign cmd_ok = s.cmd_ok;
   assign tx_ready = s.tx_ready;
   assign rx_valid = s.sk0v;
   assign rx_data = s.sk0d;
   assign st_rx_count = s.st_rx;
   assign st_tx_count = s.st_tx;
   assign st_lost = s.st_lost;
   assign st_rx_err = s.st_ferr;
   assign st_parity_err = s.st_perr;
   assign txd = s.txd;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_open_once;
      acc && pok && cmd_code == CMD_OPEN && s.open[p] |=> cmd_done && !cmd_ok;
   endproperty
   a_open_once: assert property (p_open_once)
      else $error("second open accepted");

   property p_port_zero;
      acc && port_device_specifier == 3'h0 && cmd_code == CMD_OPEN &&
         first_aux_parameter == DIR_OUT_B && !s.open[0] && !s.conc
         |=> s.open[0] && s.cport == 2'h0 && cmd_ok;
   endproperty
   a_port_zero: assert property (p_port_zero)
      else $error("port index zero not taken as port one");

   property p_conc_end;
      s.conc && !n.conc |-> s.closing && s.txcnt == '0;
   endproperty
   a_conc_end: assert property (p_conc_end)
      else $error("concurrent mode ended without close");

   property p_close_drop;
      $rose(s.closing) |-> s.rxcnt == '0 && !s.sk0v && !s.rd_pend;
   endproperty
   a_close_drop: assert property (p_close_drop)
      else $error("receive data survived close");

   property p_start_aux;
      acc && cmd_code == CMD_START &&
         (first_aux_parameter != 8'h00 || second_aux_parameter != 8'h00)
         |=> !cmd_ok;
   endproperty
   a_start_aux: assert property (p_start_aux)
      else $error("start accepted with nonzero aux");

   property p_word8;
      s.conc && s.dirout[s.cport] |-> s.wsz[s.cport] == WSZ_8;
   endproperty
   a_word8: assert property (p_word8)
      else $error("short word in concurrent output");

   property p_drain;
      s.conc && s.txcnt != '0 && s.txst == TX_IDLE
         |=> s.txst == TX_LOAD ##1 s.txst == TX_SHIFT;
   endproperty
   a_drain: assert property (p_drain)
      else $error("pending transmit byte not drained");

   property p_full_stall;
      s.txcnt == TX_FULL |-> !tx_ready;
   endproperty
   a_full_stall: assert property (p_full_stall)
      else $error("writer not stalled on full buffer");

   property p_overwrite;
      rpush && !rpop && s.rxcnt == RX_FULL && !clr_rx
         |=> s.lost && s.rxcnt == RX_FULL;
   endproperty
   a_overwrite: assert property (p_overwrite)
      else $error("overflow not recorded");

   property p_status_clear;
      acc && pok && cmd_code == CMD_STATUS && s.open[p] &&
         !(s.conc && p != s.cport) && !rpush
         |=> cmd_ok && !s.lost && st_lost == $past(s.lost);
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("status did not report and clear loss");

   property p_cr_flush;
      tpush && !s.conc && tdat == CHR_CR |=> s.blk_send;
   endproperty
   a_cr_flush: assert property (p_cr_flush)
      else $error("carriage return did not flush block");

   c_start: cover property (acc && cmd_code == CMD_START ##1 cmd_ok);
   c_overflow: cover property (rpush && !rinc);
   c_block: cover property ($rose(s.blk_send) ##[1:1000] !s.blk_send);
   c_close: cover property (s.closing ##1 !s.closing);
endmodule : spsb_port

// File: spsb_peer.sv
`timescale 1ns/100ps
module spsb_peer #(parameter int BC = 20)
(
   input wire logic clock,
   input wire logic line_in,
   output logic line_out
);
   byte unsigned got_q[$];
   logic [7:0] d;
   // line rests at mark between frames, so no stale data bit shows
   initial line_out = 1'b1;
   // ---------------------------------------------
   // frame capture, 8 data bits lsb first
   // ---------------------------------------------
   always
   begin
      @(negedge line_in);
      repeat (BC + BC / 2) @(posedge clock);
      for (int k = 0; k < 8; k++)
      begin
         d[k] = line_in;
         repeat (BC) @(posedge clock);
      end
      got_q.push_back(d);
   end
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++)
      begin
         line_out <= f[k];
         repeat (BC) @(posedge clock);
      end
   endtask : send
endmodule : spsb_peer

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
   import spsb_pkg::*;
   localparam int BC = 20;
   localparam int RXD = 4;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic [2:0] port_device_specifier = 3'h0;
   logic [7:0] first_aux_parameter = 8'h00;
   logic [7:0] second_aux_parameter = 8'h00;
   logic tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic rx_ready = 1'b0;
   logic xl = 1'b0;
   logic cmd_done, cmd_ok, tx_ready, rx_valid, peer_line;
   logic st_lost, st_rx_err, st_parity_err;
   logic [7:0] rx_data;
   logic [$clog2(RXD+1)-1:0] st_rx_count, st_tx_count;
   logic [3:0] txd;
   int n_fail = 0;
   int check_count = 0;
   int seed = 32'h356099bc;
   byte unsigned exp_q[$];
   byte unsigned rxm[$];
   always #50 clock = ~clock;
   spsb_port #(.TX_DEPTH(RXD), .RX_DEPTH(RXD), .BIT_CYC_300(BC),
      .BIT_CYC_1200(16), .BIT_CYC_2400(12)) dut (.clock(clock),
      .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .port_device_specifier(port_device_specifier),
      .first_aux_parameter(first_aux_parameter),
      .second_aux_parameter(second_aux_parameter), .cmd_done(cmd_done),
      .cmd_ok(cmd_ok), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .st_rx_count(st_rx_count),
      .st_tx_count(st_tx_count), .st_lost(st_lost), .st_rx_err(st_rx_err),
      .st_parity_err(st_parity_err), .rxd({3'h7, peer_line}), .txd(txd));
   spsb_peer #(.BC(BC)) u_peer (.clock(clock), .line_in(txd[0]),
      .line_out(peer_line));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("mismatches %0d checks %0d", n_fail, check_count);
      if (n_fail == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic bound(input int i);
      if (i >= 9999)
      begin
         chk(8'h00, 8'h01);
         close_out();
      end
   endtask : bound
   task automatic cmd(input logic [7:0] c, input logic [2:0] p,
      input logic [7:0] a1, input logic [7:0] a2, input logic ok);
      int i;
      @(posedge clock);
      cmd_code <= c;
      port_device_specifier <= p;
      first_aux_parameter <= a1;
      second_aux_parameter <= a2;
      cmd_valid <= 1'b1;
      for (i = 0; i < 9999; i++)
      begin
         @(posedge clock);
         cmd_valid <= 1'b0;
         #1;
         if (cmd_done === 1'b1) break;
      end
      bound(i);
      chk(8'(cmd_ok), 8'(ok));
   endtask : cmd
   task automatic put(input logic [7:0] d);
      int i;
      logic r;
      @(posedge clock);
      tx_valid <= 1'b1;
      tx_data <= d;
      exp_q.push_back((xl && d == CHR_EOL) ? CHR_CR : d);
      for (i = 0; i < 9999; i++)
      begin
         #1;
         r = tx_ready;
         @(posedge clock);
         if (r === 1'b1) break;
      end
      tx_valid <= 1'b0;
      bound(i);
   endtask : put
   task automatic get;
      int i;
      logic r;
      logic [7:0] v;
      @(posedge clock);
      rx_ready <= 1'b1;
      for (i = 0; i < 9999; i++)
      begin
         #1;
         r = rx_valid;
         v = rx_data;
         @(posedge clock);
         if (r === 1'b1) break;
      end
      rx_ready <= 1'b0;
      bound(i);
      chk(v, rxm.pop_front());
   endtask : get
   task automatic send_n(input int n);
      repeat (n) put(8'($random(seed)));
   endtask : send_n
   task automatic feed(input int n);
      logic [7:0] b;
      repeat (n)
      begin
         b = 8'($random(seed));
         // output stage keeps its two bytes; the buffer loses its oldest
         if (rxm.size() == RXD + 2) rxm.delete(2);
         rxm.push_back(b);
         u_peer.send(b);
      end
      repeat (BC) @(posedge clock);
   endtask : feed
   task automatic drain;
      int i;
      for (i = 0; i < 9999 && u_peer.got_q.size() < exp_q.size(); i++)
         @(posedge clock);
      bound(i);
      while (exp_q.size() > 0)
         chk(u_peer.got_q.pop_front(), exp_q.pop_front());
   endtask : drain
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk(8'({cmd_done, tx_ready, rx_valid}), 8'h00);
      chk(8'(txd), 8'h0F);
      cmd(CMD_OPEN, 3'h0, DIR_IO_C, 8'h00, 1'b1);
      cmd(CMD_OPEN, 3'h1, DIR_IO_C, 8'h00, 1'b0);
      cmd(CMD_OPEN, 3'h5, DIR_IO_C, 8'h00, 1'b0);
      cmd(CMD_OPEN, 3'h2, 8'h07, 8'h00, 1'b0);
      cmd(CMD_START, 3'h1, 8'h00, 8'h01, 1'b0);
      cmd(CMD_START, 3'h1, 8'h00, 8'h00, 1'b1);
      cmd(CMD_OPEN, 3'h2, DIR_OUT_B, 8'h00, 1'b0);
      cmd(CMD_BAUD, 3'h1, 8'h31, 8'h00, 1'b0);
      $display("test sessions done");
      send_n(6);
      drain;
      feed(RXD + 3);
      cmd(CMD_STATUS, 3'h1, 8'h00, 8'h00, 1'b1);
      chk(8'(st_lost), 8'h01);
      chk(8'(st_rx_count), 8'(rxm.size() - 2));
      chk(8'(st_tx_count), 8'h00);
      chk(8'({st_rx_err, st_parity_err}), 8'h00);
      get;
      cmd(CMD_STATUS, 3'h1, 8'h00, 8'h00, 1'b1);
      chk(8'(st_lost), 8'h00);
      chk(8'(st_rx_count), 8'(rxm.size() - 2));
      send_n(2);
      cmd(CMD_CLOSE, 3'h1, 8'h00, 8'h00, 1'b1);
      drain;
      rxm.delete();
      $display("test concurrent done");
      cmd(CMD_START, 3'h1, 8'h00, 8'h00, 1'b0);
      cmd(CMD_OPEN, 3'h1, DIR_IO_C, 8'h00, 1'b1);
      cmd(CMD_START, 3'h1, 8'h00, 8'h00, 1'b1);
      cmd(CMD_STATUS, 3'h1, 8'h00, 8'h00, 1'b1);
      chk(8'(st_rx_count), 8'h00);
      feed(1);
      get;
      cmd(CMD_CLOSE, 3'h1, 8'h00, 8'h00, 1'b1);
      cmd(CMD_XLAT, 3'h1, 8'h01, 8'h00, 1'b1);
      xl = 1'b1;
      cmd(CMD_OPEN, 3'h0, DIR_OUT_B, 8'h00, 1'b1);
      put(8'h41);
      put(CHR_EOL);
      drain;
      put(8'h5A);
      cmd(CMD_FORCE, 3'h1, 8'h00, 8'h00, 1'b1);
      drain;
      for (int k = 0; k < RXD; k++)
         put(8'(8'h30 + k));
      drain;
      cmd(CMD_START, 3'h1, 8'h00, 8'h00, 1'b0);
      cmd(CMD_BAUD, 3'h1, 8'h20, 8'h00, 1'b1);
      cmd(CMD_CLOSE, 3'h1, 8'h00, 8'h00, 1'b1);
      cmd(CMD_OPEN, 3'h1, DIR_IO_C, 8'h00, 1'b1);
      cmd(CMD_START, 3'h1, 8'h00, 8'h00, 1'b0);
      $display("test block done");
      close_out();
   end
endmodule : testbench
